// ---- design/eis_slave.sv ----
// How it works
// RULE1 - start is data falling while clock stays high; master makes it, we detect it
// RULE2 - master issues a start before every instruction it sends
// RULE3 - start detection runs always, except during an internal write cycle
// RULE4 - stop is data rising while clock high; it ends the current exchange
// RULE5 - stop closing a write instruction launches the internal write cycle
// RULE6 - received data is captured on each rising serial clock edge
// RULE7 - transmitter keeps data stable around rising clock, changes only while low
// RULE8 - after eight bits data is released; receiver pulls low on ninth pulse
// RULE9 - select byte acknowledged only for type 1010b or 1011b
// RULE10 - select byte chip-enable bit must equal the strap pin level
// RULE11 - last select bit gives direction: one reads, zero writes
// RULE12 - bytes arrive most significant bit first
// RULE13 - matching select acknowledged in ninth slot; mismatch leaves bus, goes standby
// RULE14 - two address bytes follow, upper first, each acknowledged
// RULE15 - id page uses A7..A0 only; bit 10 picks write/status or lock
// RULE16 - device is slave only, never drives the clock nor starts transfers
// RULE17 - main array: two select bits give the top of an 18-bit address
// RULE18 - with write protect high select and address acked, data bytes not
// RULE19 - during the internal write cycle data output is off, requests ignored
// RULE20 - a start in mid transaction aborts the byte and restarts select reception
module eis_slave (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // serial bus pins
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output logic               sda_out,
  output logic               sda_oe,
  // strap and protection pins
  input  wire logic          chip_select_strap,
  input  wire logic          write_protect_input,
  // array core status
  input  wire logic          write_busy,
  input  wire logic          id_locked,
  // decoded request towards the array core
  output eis_pkg::eis_target_s target,
  output logic               target_valid,
  output logic               read_select,
  output logic [7:0]         data_byte,
  output logic               data_strobe,
  output logic               write_start
);

  // ==========================================================
  // pin synchronisation
  logic [3:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic       wp_s;
  logic       scl_d;
  logic       sda_d;

  eis_sync u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({write_protect_input, chip_select_strap, sda_in, scl_in}),
    .q   (pins_s)
  );

  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[2];
  assign wp_s    = pins_s[3];

  // one more stage of clock and data to find their edges
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // ==========================================================
  // bus events
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;

  assign start_cond = scl_d && scl_s && sda_d && !sda_s;  // RULE1
  assign stop_cond  = scl_d && scl_s && !sda_d && sda_s;  // RULE4
  assign scl_rise   = !scl_d && scl_s;
  assign scl_fall   = scl_d && !scl_s;

  // ==========================================================
  // protocol state
  eis_pkg::eis_state_e  state,       next_state;
  logic [3:0]           bit_cnt,     next_bit_cnt;
  logic [7:0]           shreg,       next_shreg;
  logic                 sel_id,      next_sel_id;
  logic [1:0]           sel_top,     next_sel_top;
  logic                 data_ok,     next_data_ok;
  logic                 next_sda_oe;
  eis_pkg::eis_target_s next_target;
  logic                 next_target_valid;
  logic                 next_read_select;
  logic [7:0]           next_data_byte;
  logic                 next_data_strobe;
  logic                 next_write_start;
  logic                 receiving;

  // the ack slot must finish even after a mismatch moved us to standby
  assign receiving = (state == eis_pkg::EIS_DEVSEL) || (state == eis_pkg::EIS_ADDR_HI) ||
                     (state == eis_pkg::EIS_ADDR_LO) || (state == eis_pkg::EIS_DATA) ||
                     (bit_cnt == eis_pkg::CNT_ACK);

  // next values of the whole byte engine
  always_comb begin
    next_state        = state;
    next_bit_cnt      = bit_cnt;
    next_shreg        = shreg;
    next_sel_id       = sel_id;
    next_sel_top      = sel_top;
    next_data_ok      = data_ok;
    next_sda_oe       = sda_oe;
    next_target       = target;
    next_target_valid = 1'b0;
    next_read_select  = read_select;
    next_data_byte    = data_byte;
    next_data_strobe  = 1'b0;
    next_write_start  = 1'b0;
    if (write_busy) begin  // RULE19
      // deaf and silent; a start here is not even watched
      next_state       = eis_pkg::EIS_IDLE;  // RULE3
      next_bit_cnt     = eis_pkg::CNT_ZERO;
      next_sda_oe      = 1'b0;
      next_read_select = 1'b0;
      next_data_ok     = 1'b0;
    end else if (start_cond) begin  // RULE20
      next_state       = eis_pkg::EIS_DEVSEL;  // RULE3
      next_bit_cnt     = eis_pkg::CNT_ZERO;
      next_sda_oe      = 1'b0;
      next_read_select = 1'b0;
      next_data_ok     = 1'b0;
    end else if (stop_cond) begin
      // only a stop in the clock pulse right after a data ack commits the write;
      // that pulse's rise was already counted as bit one of a byte that never comes
      if ((state == eis_pkg::EIS_DATA) && (bit_cnt == eis_pkg::CNT_STOP_SLOT) && data_ok) begin
        next_write_start = 1'b1;  // RULE5
      end
      next_state       = eis_pkg::EIS_IDLE;  // RULE4
      next_bit_cnt     = eis_pkg::CNT_ZERO;
      next_sda_oe      = 1'b0;
      next_read_select = 1'b0;
      next_data_ok     = 1'b0;
    end else if (receiving) begin
      if (scl_rise && (bit_cnt < eis_pkg::CNT_BYTE)) begin
        next_shreg   = {shreg[6:0], sda_s};  // RULE6 RULE12
        next_bit_cnt = bit_cnt + 4'h1;
      end else if (scl_fall && (bit_cnt == eis_pkg::CNT_BYTE)) begin
        // clock just went low after bit eight: decide the ack for slot nine
        next_bit_cnt = eis_pkg::CNT_ACK;  // RULE8
        unique case (state)
          eis_pkg::EIS_DEVSEL: begin
            if (eis_pkg::sel_match(shreg, strap_s)) begin  // RULE9 RULE10
              next_sda_oe  = 1'b1;  // RULE13
              next_sel_id  = shreg[eis_pkg::IDX_ID_TYPE];
              next_sel_top = {shreg[eis_pkg::IDX_TOP_HI], shreg[eis_pkg::IDX_TOP_LO]};
              if (shreg[eis_pkg::IDX_RW]) begin  // RULE11
                next_read_select = 1'b1;
                next_state       = eis_pkg::EIS_READ;
              end else begin
                next_state       = eis_pkg::EIS_ADDR_HI;
              end
            end else begin
              next_state = eis_pkg::EIS_STANDBY;  // RULE13
            end
          end
          eis_pkg::EIS_ADDR_HI: begin
            next_sda_oe              = 1'b1;  // RULE14 RULE18
            next_target.addr[15:8]   = shreg;
            next_target.lock_op      = sel_id && shreg[eis_pkg::IDX_LOCK_OP];  // RULE15
            next_state               = eis_pkg::EIS_ADDR_LO;
          end
          eis_pkg::EIS_ADDR_LO: begin
            next_sda_oe              = 1'b1;  // RULE14
            next_target.addr[7:0]    = shreg;
            next_target.id_page      = sel_id;
            // id page ignores every upper bit; only the byte index counts
            if (sel_id) begin
              next_target.addr[17:8] = 10'h000;  // RULE15
            end else begin
              next_target.addr[17:16] = sel_top;  // RULE17
            end
            next_target_valid        = 1'b1;
            next_state               = eis_pkg::EIS_DATA;
          end
          eis_pkg::EIS_DATA: begin
            next_data_byte   = shreg;
            next_data_strobe = 1'b1;
            if (!wp_s && !(sel_id && id_locked)) begin  // RULE18
              next_sda_oe  = 1'b1;
              next_data_ok = 1'b1;
            end
          end
          default: begin
            next_state = eis_pkg::EIS_IDLE;
          end
        endcase
      end else if (scl_fall && (bit_cnt == eis_pkg::CNT_ACK)) begin
        next_bit_cnt = eis_pkg::CNT_ZERO;  // RULE8
        next_sda_oe  = 1'b0;
      end
    end
  end

  // registers of the byte engine
  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= eis_pkg::EIS_IDLE;
      bit_cnt      <= eis_pkg::CNT_ZERO;
      shreg        <= eis_pkg::BYTE_RST;
      sel_id       <= 1'b0;
      sel_top      <= 2'h0;
      data_ok      <= 1'b0;
      sda_oe       <= 1'b0;
      target       <= eis_pkg::TARGET_RST;
      target_valid <= 1'b0;
      read_select  <= 1'b0;
      data_byte    <= eis_pkg::BYTE_RST;
      data_strobe  <= 1'b0;
      write_start  <= 1'b0;
    end else begin
      state        <= next_state;
      bit_cnt      <= next_bit_cnt;
      shreg        <= next_shreg;
      sel_id       <= next_sel_id;
      sel_top      <= next_sel_top;
      data_ok      <= next_data_ok;
      sda_oe       <= next_sda_oe;
      target       <= next_target;
      target_valid <= next_target_valid;
      read_select  <= next_read_select;
      data_byte    <= next_data_byte;
      data_strobe  <= next_data_strobe;
      write_start  <= next_write_start;
    end
  end

  // open drain: the pin only ever pulls low, and there is no clock output at all
  always_ff @(posedge clk) begin
    sda_out <= 1'b0;  // RULE16
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_restart: assert property ( // RULE20
    start_cond && !write_busy |=> state == eis_pkg::EIS_DEVSEL && bit_cnt == 4'h0 && !sda_oe)
    else $error("start did not restart select reception");
  a_busy_deaf: assert property (write_busy |=> !sda_oe && state == eis_pkg::EIS_IDLE) // RULE19
    else $error("bus answered during write cycle");
  a_sel_reject: assert property ( // RULE9
    state == eis_pkg::EIS_DEVSEL && scl_fall && bit_cnt == 4'h8 && !eis_pkg::sel_match(shreg, strap_s)
    |=> state == eis_pkg::EIS_STANDBY && !sda_oe)
    else $error("mismatching select byte was acknowledged");
  a_ce_compare: assert property ( // RULE10
    state == eis_pkg::EIS_DEVSEL && scl_fall && bit_cnt == 4'h8 && shreg[3] != strap_s |=> !sda_oe)
    else $error("chip-enable mismatch acknowledged");
  a_dir_select: assert property ( // RULE11 RULE13
    state == eis_pkg::EIS_DEVSEL && scl_fall && bit_cnt == 4'h8 && eis_pkg::sel_match(shreg, strap_s)
    |=> sda_oe && read_select == $past(shreg[0]) && (state == eis_pkg::EIS_READ) == $past(shreg[0]))
    else $error("select direction handled wrongly");
  a_ack_slot: assert property (sda_oe |-> bit_cnt == 4'h9 && sda_out == 1'b0) // RULE8 RULE16
    else $error("data driven outside ack slot");
  a_addr_acked: assert property ( // RULE14
    (state == eis_pkg::EIS_ADDR_HI || state == eis_pkg::EIS_ADDR_LO) && scl_fall && bit_cnt == 4'h8 &&
    !start_cond && !stop_cond && !write_busy |=> sda_oe)
    else $error("address byte not acknowledged");
  a_wp_nack: assert property ( // RULE18
    state == eis_pkg::EIS_DATA && scl_fall && bit_cnt == 4'h8 && wp_s
    |=> !sda_oe ##1 (!data_ok || $past(data_ok, 2)))
    else $error("data byte acked while protected");
  a_shift_msb: assert property ( // RULE6 RULE12
    receiving && scl_rise && bit_cnt < 4'h8 && !start_cond && !stop_cond && !write_busy
    |=> shreg[0] == $past(sda_s) && shreg[7:1] == $past(shreg[6:0]))
    else $error("bit not shifted in msb first");
  a_write_cause: assert property ( // RULE5
    write_start |-> $past(stop_cond) && $past(state) == eis_pkg::EIS_DATA && $past(data_ok))
    else $error("write launched without committed data");
  a_top_bits: assert property (target_valid && !target.id_page |-> target.addr[17:16] == sel_top) // RULE17
    else $error("top address bits not taken from select");

  // outcomes of stop, of the ack slot, of the data byte, of the standby and read states and of the decoded target
  a_stop_idle: assert property ( // RULE4
    stop_cond && !write_busy |=> state == eis_pkg::EIS_IDLE && !sda_oe && !read_select)
    else $error("stop did not end the exchange");
  a_write_launch: assert property ( // RULE5
    stop_cond && !write_busy && state == eis_pkg::EIS_DATA && bit_cnt == eis_pkg::CNT_STOP_SLOT && data_ok
    |=> write_start)
    else $error("stop after acked data did not launch write");
  a_ack_release: assert property (sda_oe && scl_fall |=> !sda_oe) // RULE8
    else $error("ack held past the ninth clock");
  a_data_strobe: assert property ( // RULE6
    state == eis_pkg::EIS_DATA && scl_fall && bit_cnt == 4'h8 && !write_busy
    |=> data_strobe && data_byte == $past(shreg))
    else $error("received data byte not handed over");
  a_standby_deaf: assert property ( // RULE13
    state == eis_pkg::EIS_STANDBY && bit_cnt == 4'h0 && !start_cond && !write_busy
    |=> !sda_oe && (state == eis_pkg::EIS_STANDBY || state == eis_pkg::EIS_IDLE))
    else $error("deselected device left standby without start");
  a_read_hold: assert property (state == eis_pkg::EIS_READ |-> read_select) // RULE11
    else $error("read state without read select");
  a_id_index: assert property (target_valid && target.id_page |-> target.addr[17:8] == 10'h000) // RULE15
    else $error("id page upper address bits not ignored");
  a_lock_main: assert property (target_valid && !target.id_page |-> !target.lock_op) // RULE15
    else $error("lock flagged for main array access");

  c_write_done: cover property (write_start);
  c_read_sel:   cover property ($rose(read_select));
  c_standby:    cover property (state == eis_pkg::EIS_STANDBY);
  c_id_lock:    cover property (target_valid && target.lock_op);
  c_wp_nack:    cover property (state == eis_pkg::EIS_DATA && scl_fall && bit_cnt == 4'h8 && wp_s);

endmodule : eis_slave

// ---- design/eis_pkg.sv ----
package eis_pkg;

  // ==========================================================
  // select byte layout
  localparam logic [3:0] TYPE_MEM      = 4'hA;  // device type: main array
  localparam logic [3:0] TYPE_ID       = 4'hB;  // device type: identification page
  localparam int         IDX_CE        = 3;     // chip-enable bit of the select byte
  localparam int         IDX_TOP_HI    = 2;     // addr_bit_top in the select byte
  localparam int         IDX_TOP_LO    = 1;     // addr_bit_next_top in the select byte
  localparam int         IDX_RW        = 0;     // direction bit, 1 = read
  localparam int         IDX_ID_TYPE   = 4;     // low bit of the type field
  localparam int         IDX_LOCK_OP   = 2;     // address bit 10 inside the upper address byte

  // ==========================================================
  // bit counter
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [3:0] CNT_BYTE      = 4'h8;  // eight data bits taken
  localparam logic [3:0] CNT_ACK       = 4'h9;  // ninth clock, acknowledge slot
  localparam logic [3:0] CNT_STOP_SLOT = 4'h1;  // tenth clock: its rise is counted before a stop shows

  // ==========================================================
  // reset values
  localparam logic [3:0] SYNC_RST      = 4'hF;  // pins idle high on a pulled-up bus
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam int         ADDR_W        = 18;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    EIS_IDLE    = 3'h0,
    EIS_DEVSEL  = 3'h1,
    EIS_ADDR_HI = 3'h3,
    EIS_ADDR_LO = 3'h2,
    EIS_DATA    = 3'h6,
    EIS_READ    = 3'h7,
    EIS_STANDBY = 3'h5
  } eis_state_e;

  typedef struct packed {
    logic              id_page;  // identification page selected
    logic              lock_op;  // id page lock instruction (address bit 10 set)
    logic [ADDR_W-1:0] addr;     // full byte address
  } eis_target_s;

  localparam eis_target_s TARGET_RST = '{id_page: 1'b0, lock_op: 1'b0, addr: 18'h00000};

  // select byte accepted: known type and matching chip-enable bit
  function automatic logic sel_match(input logic [7:0] sel, input logic strap);
    sel_match = ((sel[7:4] == TYPE_MEM) || (sel[7:4] == TYPE_ID)) && (sel[IDX_CE] == strap);
  endfunction : sel_match

endpackage : eis_pkg

// ---- design/eis_sync.sv ----
module eis_sync (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [3:0] d,
  output logic      [3:0] q
);

  logic [3:0] meta;

  // ==========================================================
  // two-stage synchroniser; only the second stage is visible
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= eis_pkg::SYNC_RST;
      q    <= eis_pkg::SYNC_RST;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : eis_sync

// ---- testbench/eis_master.sv ----
module eis_master (
  // clock
  input  wire logic clk,
  // serial bus, open drain towards the wired data line
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // all timing counts whole system clocks, 8 clocks per serial bit
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // also works as a repeated start from the clock-low state
  task automatic start();
    sda_low <= 1'b0;
    tick(4); // a slave ack stands ~3 clocks past the clock fall; raising scl sooner makes a false stop
    scl <= 1'b1;
    tick(2);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_low <= 1'b0;
    tick(4);
  endtask : stop

  // data moves mid low phase so it is stable around the rising edge
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      tick(2);
      sda_low <= ~b[i];
      tick(2);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
    end
  endtask : send_bits

  // ack is 1 when the receiver pulled the line low in the ninth slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    send_bits(b, 8);
    tick(2);
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    @(negedge clk);
    ack = ~sda_line;
    @(posedge clk);
    scl <= 1'b0;
  endtask : send_byte

endmodule : eis_master

// ---- testbench/test_eis_slave.sv ----
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module test_eis_slave;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst, strap, wp, busy, locked, scl, m_low, sda_line;
  logic sda_out, sda_oe, target_valid, read_select, data_strobe, write_start;
  logic [7:0] data_byte;
  eis_pkg::eis_target_s target, last_tgt;
  int errors = 0;
  int samples_checked = 0;
  int n_tv, n_ws, n_ds, cyc;

  // ==========================================================
  // 25 MHz system clock and the wired-and data line with pull-up
  always #20 clk = ~clk;
  assign sda_line = ((sda_oe & ~sda_out) | m_low) ? 1'b0 : 1'b1;

  eis_slave DUT (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap(strap), .write_protect_input(wp), .write_busy(busy), .id_locked(locked),
    .target(target), .target_valid(target_valid), .read_select(read_select),
    .data_byte(data_byte), .data_strobe(data_strobe), .write_start(write_start)
  );

  eis_master master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));

  // pulses caught on the falling edge, clear of the rising-edge updates
  always @(negedge clk) begin
    if (target_valid === 1'b1) begin
      n_tv++;
      last_tgt = target;
    end
    if (write_start === 1'b1) n_ws++;
    if (data_strobe === 1'b1) n_ds++;
    cyc++;
    if (cyc > 50000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // start, then n bytes of bs from the top, each ack compared
  task automatic seq(input logic [31:0] bs, input int n, input logic [3:0] exp_ack);
    logic ack;
    n_tv = 0;
    n_ws = 0;
    n_ds = 0;
    master.start();
    for (int k = 0; k < n; k++) begin
      master.send_byte(bs[31-8*k -: 8], ack);
      `CHK(ack, exp_ack[3-k])
    end
  endtask : seq

  task automatic t_write();
    seq(32'hAC5AC396, 4, 4'hF);
    master.stop();
    `CHK(last_tgt, 20'h25AC3)
    `CHK(data_byte, 8'h96)
    `CHK(n_ds, 1)
    `CHK(n_ws, 1)
    `CHK(read_select, 1'b0)
    seq(32'hAC5AC300, 3, 4'hE);
    master.stop();
    `CHK(n_tv, 1)
    `CHK(n_ws, 0)
    $display("write test done, errors=%0d", errors);
  endtask : t_write

  // every type code; a standby device must also ignore the next byte
  task automatic t_select();
    logic [3:0] t;
    for (int i = 0; i < 16; i++) begin
      t = 4'(i);
      seq({t, 4'h8, 24'h0}, 2, (t == 4'hA || t == 4'hB) ? 4'hC : 4'h0);
      master.stop();
    end
    seq(32'hA0000000, 2, 4'h0);
    master.stop();
    strap <= 1'b0;
    seq(32'hA0000000, 1, 4'h8);
    master.stop();
    strap <= 1'b1;
    $display("select test done, errors=%0d", errors);
  endtask : t_select

  // protection nacks data only; locked id page likewise
  task automatic t_protect();
    wp <= 1'b1;
    seq(32'hAC000111, 4, 4'hE);
    master.stop();
    `CHK(n_ds, 1)
    `CHK(n_ws, 0)
    wp <= 1'b0;
    locked <= 1'b1;
    seq(32'hB8FF77AA, 4, 4'hE);
    master.stop();
    `CHK(last_tgt, 20'hC0077)
    `CHK(n_ws, 0)
    locked <= 1'b0;
    seq(32'hB8FB1255, 4, 4'hF);
    master.stop();
    `CHK(last_tgt, 20'h80012)
    `CHK(n_ws, 1)
    $display("protect test done, errors=%0d", errors);
  endtask : t_protect

  task automatic t_read();
    seq(32'hAD000000, 1, 4'h8);
    master.tick(4);
    `CHK(read_select, 1'b1)
    master.stop();
    `CHK(read_select, 1'b0)
    $display("read test done, errors=%0d", errors);
  endtask : t_read

  // start in mid byte drops the byte and restarts select reception
  task automatic t_restart();
    seq(32'hAC000000, 1, 4'h8);
    master.send_bits(8'h12, 4);
    seq(32'hA8123456, 4, 4'hF);
    master.stop();
    `CHK(last_tgt, 20'h01234)
    `CHK(data_byte, 8'h56)
    `CHK(n_ws, 1)
    $display("restart test done, errors=%0d", errors);
  endtask : t_restart

  task automatic t_busy();
    busy <= 1'b1;
    seq(32'hA8000000, 2, 4'h0);
    master.stop();
    busy <= 1'b0;
    seq(32'hA8000000, 1, 4'h8);
    master.stop();
    `CHK(sda_out, 1'b0)
    $display("busy test done, errors=%0d", errors);
  endtask : t_busy

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    strap = 1'b1;
    wp = 1'b0;
    busy = 1'b0;
    locked = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_write();
    t_select();
    t_protect();
    t_read();
    t_restart();
    t_busy();
    print_verdict();
  end

endmodule : test_eis_slave
